// File: logic/capture_seq_pkg.sv
// Constants, register map and types of the camera capture sequencer
`default_nettype none
package capture_seq_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CMD = 6'h04;
  localparam logic [5:0] OFS_EXPO = 6'h08;
  localparam logic [5:0] OFS_PERIOD = 6'h0C;
  localparam logic [5:0] OFS_FLASH = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_IGNORED = 6'h18;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h1C;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OPEN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_FLASH_EN_BIT = 3;
  localparam int CTRL_FLASH_MAN_BIT = 4;
  localparam int CTRL_GPO_BIT = 5;
  localparam int CMD_SNAP_BIT = 0;
  localparam int CMD_LIVE_BIT = 1;
  localparam int CMD_STOP_BIT = 2;
  localparam int STAT_LIVE_BIT = 3;
  localparam int STAT_ARMED_BIT = 4;
  localparam int STAT_TRIG_LVL_BIT = 5;
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_IGNORED_BIT = 1;
  localparam int IRQ_MODE_ERR_BIT = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] EXPO_RST = 16'h03E8;
  localparam logic [15:0] PERIOD_RST = 16'h07D0;
  localparam logic [15:0] FLASH_RST = 16'h0000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int READOUT_NS = 20000;
  localparam int READOUT_CYC = (READOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_FREERUN = 2'b01,
    MODE_SW_TRIG = 2'b10,
    MODE_HW_TRIG = 2'b11
  } mode_type;

  typedef enum logic [2:0] {
    ST_STBY = 3'b000,
    ST_FREE = 3'b001,
    ST_TIDLE = 3'b010,
    ST_EXPOSE = 3'b011,
    ST_READ = 3'b100,
    ST_XFER = 3'b101
  } seq_state_type;

endpackage : capture_seq_pkg
`default_nettype wire

// File: logic/trigger_edge_sync.sv
// Trigger input synchroniser and active-edge detector
`timescale 1ns/1ps
`default_nettype none
module trigger_edge_sync
#(
  parameter bit ACTIVE_HIGH = 1'b1
)
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic trig_i,
  output logic level_o,
  output logic edge_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic edge_p;
  } sync_state_type;

  sync_state_type r;
  sync_state_type n;

  always_comb
  begin
    n = r;
    n.meta = ACTIVE_HIGH ? trig_i : ~trig_i;
    n.sync = r.meta;
    n.prev = r.sync;
    // One pulse per pulse of the pin, however long it lasts
    n.edge_p = r.sync & ~r.prev;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      r <= '0;
    else
      r <= n;
  end

  assign level_o = r.prev;
  assign edge_o = r.edge_p;

endmodule : trigger_edge_sync
`default_nettype wire

// File: logic/capture_sequencer.sv
// Camera capture mode sequencer with Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module capture_sequencer
  import capture_seq_pkg::*;
#(
  parameter int CW = 16,
  parameter int IW = 16,
  parameter int RD_CYC = READOUT_CYC
)
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic trig_i,
  input wire logic xfer_done_i,
  output logic sensor_power_o,
  output logic expose_o,
  output logic flash_o,
  output logic frame_o,
  output logic frame_black_o,
  output logic gpo_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (CW < 2 || CW > 32 || IW < 1 || IW > 32)
    $error("capture_sequencer: counter widths out of range");
  if (RD_CYC < 1 || RD_CYC >= (2 ** CW))
    $error("capture_sequencer: readout count does not fit");

  localparam logic [CW-1:0] RD_LAST = CW'(RD_CYC - 1);
  localparam logic [IW-1:0] IGN_MAX = '1;

  typedef struct packed {
    seq_state_type st;
    mode_type mode;
    logic open;
    logic flash_en;
    logic flash_man;
    logic gpo;
    logic [CW-1:0] expo;
    logic [CW-1:0] period;
    logic [CW-1:0] flash_dly;
    logic [CW-1:0] cnt;
    logic first_done;
    logic black;
    logic snap_pend;
    logic snap_take;
    logic live;
    logic armed;
    logic [IW-1:0] ignored;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic ack;
    logic [31:0] rdata;
    logic power;
    logic expose;
    logic flash;
    logic frame;
    logic frame_black;
    logic irq;
  } seq_reg_type;

  localparam seq_reg_type RST = '{
    st: ST_STBY, mode: MODE_STANDBY, open: 1'b0, flash_en: 1'b0,
    flash_man: 1'b0, gpo: 1'b0, expo: CW'(EXPO_RST),
    period: CW'(PERIOD_RST), flash_dly: CW'(FLASH_RST), cnt: '0,
    first_done: 1'b0, black: 1'b0, snap_pend: 1'b0, snap_take: 1'b0,
    live: 1'b0, armed: 1'b0, ignored: '0, istat: '0, imask: '0,
    ack: 1'b0, rdata: '0, power: 1'b0, expose: 1'b0, flash: 1'b0,
    frame: 1'b0, frame_black: 1'b0, irq: 1'b0};

  seq_reg_type r;
  seq_reg_type n;
  logic trig_level;
  logic trig_edge;

  trigger_edge_sync #(.ACTIVE_HIGH(1'b1)) u_trig
  (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .trig_i(trig_i),
    .level_o(trig_level),
    .edge_o(trig_edge)
  );

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction : merge_be

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [31:0] rv;
  logic [31:0] wm;
  logic [IRQ_W-1:0] ev;
  logic wr;
  logic rd;
  logic snap;
  logic live_on;
  logic stop;
  logic hw;
  logic busy;
  logic hit;
  logic go;
  logic last;
  logic trig_act;
  mode_type m;
  logic [CW-1:0] wv;

  always_comb
  begin
    n = r;
    ev = '0;
    m = r.mode;
    wr = avs_write_i && r.ack;
    rd = avs_read_i && r.ack;
    // One wait state: request taken on the edge where waitrequest is low
    n.ack = (avs_read_i || avs_write_i) && !r.ack;
    n.frame = 1'b0;
    n.frame_black = 1'b0;
    rv = '0;
    if (avs_address_i == OFS_CTRL)
      rv = {26'h0, r.gpo, r.flash_man, r.flash_en, r.mode, r.open};
    else if (avs_address_i == OFS_EXPO)
      rv = 32'(r.expo);
    else if (avs_address_i == OFS_PERIOD)
      rv = 32'(r.period);
    else if (avs_address_i == OFS_FLASH)
      rv = 32'(r.flash_dly);
    else if (avs_address_i == OFS_STATUS)
      rv = {26'h0, trig_level, r.armed, r.live, r.st};
    else if (avs_address_i == OFS_IGNORED)
      rv = 32'(r.ignored);
    else if (avs_address_i == OFS_IRQ_STAT)
      rv = 32'(r.istat);
    else if (avs_address_i == OFS_IRQ_MASK)
      rv = 32'(r.imask);
    if (n.ack)
      n.rdata = rv;
    wm = merge_be(rv, avs_writedata_i, avs_byteenable_i);
    wv = wm[CW-1:0];
    snap = wr && avs_address_i == OFS_CMD && wm[CMD_SNAP_BIT];
    live_on = wr && avs_address_i == OFS_CMD && wm[CMD_LIVE_BIT];
    stop = wr && avs_address_i == OFS_CMD && wm[CMD_STOP_BIT];
    hw = r.mode == MODE_HW_TRIG;
    busy = r.st == ST_EXPOSE || r.st == ST_READ || r.st == ST_XFER;
    hit = hw ? trig_edge : snap;
    go = hw ? (trig_edge && r.armed) : (snap || r.live);
    last = r.cnt == r.period - 1'b1;
    trig_act = (r.mode == MODE_SW_TRIG || hw) && (r.live || r.armed || busy);

    case (r.st)
      ST_STBY:
      begin
        n.expose = 1'b0;
        n.flash = 1'b0;
      end
      ST_FREE:
      begin
        // Exposure of the next frame runs during readout of this one
        n.cnt = last ? '0 : r.cnt + 1'b1;
        n.expose = n.cnt < r.expo;
        // Flash timing needs the end of the first frame first
        n.flash = n.expose && r.first_done && r.flash_en && r.live
                  && n.cnt >= r.flash_dly;
        if (last)
        begin
          ev[IRQ_FRAME_BIT] = 1'b1;
          n.first_done = 1'b1;
          n.black = 1'b0;
          n.snap_take = r.snap_pend;
          n.snap_pend = 1'b0;
          if (r.live || r.snap_take)
          begin
            n.frame = 1'b1;
            n.frame_black = r.black;
          end
        end
        if (snap)
          n.snap_pend = 1'b1;
      end
      ST_TIDLE:
      begin
        n.expose = 1'b0;
        n.flash = 1'b0;
        if (go)
        begin
          n.st = ST_EXPOSE;
          n.cnt = '0;
          n.expose = 1'b1;
          n.flash = r.flash_en && r.flash_dly == '0;
          if (hw && !r.live)
            n.armed = 1'b0;
        end
      end
      ST_EXPOSE:
      begin
        n.cnt = r.cnt + 1'b1;
        n.flash = r.flash_en && n.cnt >= r.flash_dly;
        if (r.cnt >= r.expo - 1'b1)
        begin
          n.st = ST_READ;
          n.cnt = '0;
          n.expose = 1'b0;
          n.flash = 1'b0;
        end
      end
      ST_READ:
      begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == RD_LAST)
        begin
          n.st = ST_XFER;
          n.frame = 1'b1;
        end
      end
      ST_XFER:
      begin
        // Re-arming waits for the host to finish taking the frame
        if (xfer_done_i)
        begin
          n.st = ST_TIDLE;
          ev[IRQ_FRAME_BIT] = 1'b1;
        end
      end
      default:
        n.st = ST_STBY;
    endcase

    if (busy && hit)
    begin
      ev[IRQ_IGNORED_BIT] = 1'b1;
      if (r.ignored != IGN_MAX)
        n.ignored = r.ignored + 1'b1;
    end

    if (snap && hw)
      n.armed = 1'b1;
    if (live_on)
    begin
      n.live = 1'b1;
      n.armed = hw;
    end
    if (stop)
    begin
      n.live = 1'b0;
      n.armed = 1'b0;
      n.snap_pend = 1'b0;
    end

    if (wr && avs_address_i == OFS_EXPO)
      n.expo = (wv == '0) ? CW'(1) : wv;
    if (wr && avs_address_i == OFS_PERIOD)
      n.period = (wv == '0) ? CW'(1) : wv;
    if (wr && avs_address_i == OFS_IRQ_MASK)
      n.imask = wm[IRQ_W-1:0];
    if (wr && avs_address_i == OFS_FLASH)
    begin
      n.flash_dly = wv;
      if (r.st == ST_FREE)
      begin
        n.cnt = '0;
        n.first_done = 1'b0;
        n.black = 1'b1;
        n.snap_take = 1'b0;
        n.flash = 1'b0;
      end
    end
    if (wr && avs_address_i == OFS_CTRL)
    begin
      n.flash_en = wm[CTRL_FLASH_EN_BIT];
      n.flash_man = wm[CTRL_FLASH_MAN_BIT];
      n.gpo = wm[CTRL_GPO_BIT];
      m = mode_type'(wm[CTRL_MODE_LSB +: 2]);
      // Free-run while triggering is still active is refused and flagged
      if (m == MODE_FREERUN && trig_act)
      begin
        m = r.mode;
        ev[IRQ_MODE_ERR_BIT] = 1'b1;
      end
      n.mode = m;
      n.open = wm[CTRL_OPEN_BIT] || m != MODE_STANDBY;
      if (m != r.mode || n.open != r.open)
      begin
        n.cnt = '0;
        n.first_done = 1'b0;
        n.black = 1'b0;
        n.snap_pend = 1'b0;
        n.snap_take = 1'b0;
        n.live = 1'b0;
        n.armed = 1'b0;
        n.expose = 1'b0;
        n.flash = 1'b0;
        if (!n.open || m == MODE_STANDBY)
          n.st = ST_STBY;
        else if (m == MODE_FREERUN)
          n.st = ST_FREE;
        else
          n.st = ST_TIDLE;
      end
    end

    n.power = n.st != ST_STBY;
    // Manual flash and the general output work in standby as well
    n.flash = n.flash || n.flash_man;
    // Clear only the bits the read returned; later events survive
    if (rd && avs_address_i == OFS_IRQ_STAT)
      n.istat = (r.istat & ~r.rdata[IRQ_W-1:0]) | ev;
    else
      n.istat = r.istat | ev;
    n.irq = |(n.istat & n.imask);
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      r <= RST;
    else
      r <= n;
  end

  assign avs_readdata_o = r.rdata;
  assign avs_waitrequest_o = !r.ack;
  assign sensor_power_o = r.power;
  assign expose_o = r.expose;
  assign flash_o = r.flash;
  assign frame_o = r.frame;
  assign frame_black_o = r.frame_black;
  assign gpo_o = r.gpo;
  assign irq_o = r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  a_ignore_count:
    assert property (busy && r.mode == MODE_HW_TRIG && trig_edge
                     && r.ignored != IGN_MAX && !avs_write_i
                     |=> r.ignored == IW'($past(r.ignored) + 1'b1))
    else $error("ignored trigger not counted");

  a_ignore_saturate:
    assert property (r.ignored == IGN_MAX |=> r.ignored == IGN_MAX)
    else $error("ignored counter wrapped");

  a_expose_cause:
    assert property ($rose(r.expose) && r.st != ST_FREE
                     |-> $past(r.st) == ST_TIDLE && r.st == ST_EXPOSE)
    else $error("exposure started without trigger");

  a_xfer_hold:
    assert property (r.st == ST_XFER && !xfer_done_i && !avs_write_i
                     |=> r.st == ST_XFER)
    else $error("transfer left before completion");

  a_first_noflash:
    assert property (r.st == ST_FREE && !r.first_done && !n.flash_man
                     |=> !flash_o)
    else $error("flash during first free-run frame");

  a_snap_disarm:
    assert property (r.st == ST_TIDLE && r.mode == MODE_HW_TRIG && r.armed
                     && !r.live && trig_edge && !avs_write_i
                     |=> !r.armed && r.st == ST_EXPOSE)
    else $error("single trigger did not disarm");

  a_readout_end:
    assert property (r.st == ST_READ && r.cnt == RD_LAST && !avs_write_i
                     |=> r.st == ST_XFER && frame_o)
    else $error("readout did not end in transfer");

  a_standby_power:
    assert property (!r.open |-> !sensor_power_o && r.st == ST_STBY)
    else $error("sensor powered while closed");

  a_freerun_wrap:
    assert property (r.st == ST_FREE && last && !avs_write_i
                     |=> r.cnt == '0 ##0 r.istat[IRQ_FRAME_BIT])
    else $error("free-run frame did not complete");

endmodule : capture_sequencer
`default_nettype wire

// File: test/capture_host_model.sv
// Host link and trigger source model for the capture sequencer bench
`timescale 1ns/1ps
`default_nettype none
module capture_host_model
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic fire_i,
  input wire logic frame_i,
  input wire logic slow_i,
  output logic trig_o,
  output logic xfer_done_o
);
  typedef struct packed {
    logic [1:0] pulse;
    logic [4:0] wait_cnt;
    logic busy;
    logic done;
  } host_state_type;
  host_state_type st_r;
  host_state_type st_nxt;
  // ------------------------------------------------------------
  // Trigger pulse three clocks wide; transfer taken after a delay
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (fire_i && st_r.pulse == 2'h0)
      st_nxt.pulse = 2'h3;
    else if (st_r.pulse != 2'h0)
      st_nxt.pulse = st_r.pulse - 2'h1;
    // Slow host keeps the device waiting long enough to see refusals
    if (frame_i)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.wait_cnt = slow_i ? 5'h0C : 5'h01;
    end
    else if (st_r.busy)
    begin
      if (st_r.wait_cnt <= 5'h01)
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
      else
        st_nxt.wait_cnt = st_r.wait_cnt - 5'h01;
    end
  end
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign trig_o = (st_r.pulse != 2'h0);
  assign xfer_done_o = st_r.done;
endmodule : capture_host_model
`default_nettype wire

// File: test/camera_capture_mode_sequencer_test.sv
// Self-checking bench for the capture sequencer
`timescale 1ns/1ps
`default_nettype none
module camera_capture_mode_sequencer_test;
  import capture_seq_pkg::*;
  localparam int RD = 4;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd_r = 1'b0;
  logic wr_r = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic trig_i, xfer_done_i, sensor_power_o, expose_o, flash_o;
  logic frame_o, frame_black_o, gpo_o, irq_o;
  logic fire_r = 1'b0;
  logic slow_r = 1'b0;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'hb8d6e5ce;
  int expo, n, tot;
  logic [31:0] v;
  logic seen;
  always #5 clock_i = ~clock_i;
  capture_sequencer #(.RD_CYC(RD)) u_capture_sequencer (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(addr),
    .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .trig_i(trig_i),
    .xfer_done_i(xfer_done_i), .sensor_power_o(sensor_power_o),
    .expose_o(expose_o), .flash_o(flash_o), .frame_o(frame_o),
    .frame_black_o(frame_black_o), .gpo_o(gpo_o), .irq_o(irq_o));
  capture_host_model u_capture_host_model (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .fire_i(fire_r),
    .frame_i(frame_o), .slow_i(slow_r), .trig_o(trig_i),
    .xfer_done_o(xfer_done_i));
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task complete_run();
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Request held until waitrequest is sampled low at a rising edge
  task bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    wr_r <= we;
    rd_r <= !we;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    // Only the bench timeout ends this wait
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clock_i);
    v = avs_readdata_o;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    @(posedge clock_i);
  endtask : bus
  task fire();
    fire_r <= 1'b1;
    @(posedge clock_i);
    fire_r <= 1'b0;
  endtask : fire
  task wait_frame(input int max);
    int i;
    i = 0;
    @(posedge clock_i);
    while (frame_o !== 1'b1 && i < max)
    begin
      @(posedge clock_i);
      i++;
    end
    chk("frame_seen", 1, frame_o);
  endtask : wait_frame
  task count_frames(input int c);
    n = 0;
    repeat (c)
    begin
      @(posedge clock_i);
      if (frame_o === 1'b1)
        n++;
    end
  endtask : count_frames
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    chk("power_closed", 0, sensor_power_o);
    bus(0, OFS_EXPO, 0);
    chk("expo_rst", EXPO_RST, v);
    bus(0, OFS_PERIOD, 0);
    chk("period_rst", PERIOD_RST, v);
    bus(0, OFS_IGNORED, 0);
    chk("ignored_rst", 0, v);
    bus(0, 6'h3C, 0);
    chk("unmapped", 0, v);
    bus(1, OFS_CTRL, 32'h20);
    chk("gpo_standby", 1, gpo_o);
    expo = 8 + ($random(seed) & 7);
    bus(1, OFS_EXPO, expo);
    bus(1, OFS_PERIOD, expo + 24 + ($random(seed) & 15));
    bus(0, OFS_EXPO, 0);
    chk("expo_kept", expo, v);
    // Hardware trigger, single arm, slow host
    slow_r <= 1'b1;
    bus(1, OFS_CTRL, 32'h07);
    chk("power_on", 1, sensor_power_o);
    count_frames(30);
    chk("idle_no_frame", 0, n);
    bus(1, OFS_CMD, 32'h1);
    fire();
    n = 0;
    while (expose_o !== 1'b1 && n < 20)
    begin
      @(posedge clock_i);
      n++;
    end
    n = 0;
    while (expose_o === 1'b1 && n < 100)
    begin
      n++;
      @(posedge clock_i);
    end
    chk("expose_len", expo, n);
    fire();
    wait_frame(RD + 8);
    fire();
    count_frames(40);
    fire();
    count_frames(40);
    chk("disarmed", 0, n);
    bus(0, OFS_IGNORED, 0);
    chk("ignored_cnt", 2, v);
    // Hardware trigger, continuous re-arm
    slow_r <= 1'b0;
    bus(1, OFS_CMD, 32'h2);
    tot = 0;
    repeat (3)
    begin
      fire();
      count_frames(expo + RD + 30);
      tot += n;
    end
    chk("hw_live_frames", 3, tot);
    bus(1, OFS_CTRL, 32'h03);
    bus(0, OFS_IRQ_STAT, 0);
    chk("mode_err_irq", 1, v[IRQ_MODE_ERR_BIT]);
    bus(0, OFS_STATUS, 0);
    chk("mode_kept", ST_TIDLE, v[2:0]);
    // Software trigger snap with frame interrupt
    bus(1, OFS_CTRL, 32'h05);
    bus(1, OFS_IRQ_MASK, 32'h1);
    bus(1, OFS_CMD, 32'h1);
    count_frames(expo + RD + 60);
    chk("sw_snap_frames", 1, n);
    chk("irq_frame", 1, irq_o);
    bus(0, OFS_IRQ_STAT, 0);
    repeat (2) @(posedge clock_i);
    chk("irq_cleared", 0, irq_o);
    // Trigger off before free-run, then live with flash
    bus(1, OFS_CTRL, 32'h00);
    chk("standby_power", 0, sensor_power_o);
    bus(1, OFS_CTRL, 32'h0B);
    bus(1, OFS_CMD, 32'h2);
    seen = 1'b0;
    n = 0;
    while (frame_o !== 1'b1 && n < 400)
    begin
      @(posedge clock_i);
      n++;
      if (frame_o !== 1'b1 && flash_o === 1'b1)
        seen = 1'b1;
    end
    chk("flash_first", 0, seen);
    n = 0;
    while (flash_o !== 1'b1 && n < 400)
    begin
      @(posedge clock_i);
      n++;
    end
    chk("flash_second", 1, flash_o);
    count_frames(200);
    chk("free_back_to_back", 1, n > 2);
    bus(1, OFS_FLASH, 32'h2);
    wait_frame(400);
    chk("black_restart", 1, frame_black_o);
    wait_frame(400);
    chk("next_not_black", 0, frame_black_o);
    bus(1, OFS_CMD, 32'h4);
    // Flash stays enabled so the snap check means something
    bus(1, OFS_CTRL, 32'h0B);
    bus(1, OFS_FLASH, 32'h0);
    bus(1, OFS_CMD, 32'h1);
    wait_frame(400);
    chk("snap_no_flash", 0, flash_o);
    complete_run();
  end
endmodule : camera_capture_mode_sequencer_test
`default_nettype wire
